// ---- core/icc_top.sv ----
// Input capture channel: control register, edge logic, buffer, interrupt
`timescale 1ns/1ps
`include "icc_params.svh"

module icc_top #(
  parameter int TB_W  = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic            CORE_CLK_I,
  input  wire logic            RST_B_I,
  // Register port
  input  wire logic [`ICC_ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [15:0]     REG_WDATA_I,
  input  wire logic            REG_WR_I,
  input  wire logic            REG_RD_I,
  output logic [15:0]          REG_RDATA_O,
  // Capture pin and processor power state
  input  wire logic            CAPT_PIN_I,
  input  wire logic            CPU_IDLE_I,
  input  wire logic            CPU_SLEEP_I,
  // Time-base values
  input  wire logic [TB_W-1:0] TMR1_VAL_I,
  input  wire logic [TB_W-1:0] TMR2_VAL_I,
  input  wire logic [TB_W-1:0] TMR3_VAL_I,
  input  wire logic [TB_W-1:0] TMR4_VAL_I,
  input  wire logic [TB_W-1:0] TMR5_VAL_I,
  input  wire logic [TB_W-1:0] PCLK_VAL_I,
  // Interrupt
  output logic                 IRQ_O
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0]            ctrl_reg;
  logic [`ICC_IRQ_W-1:0]  irq_stat_reg;
  logic [`ICC_IRQ_W-1:0]  irq_mask_reg;
  logic                   ovf_reg;
  logic [15:0]            rdata_reg;
  logic                   irq_reg;
  logic                   pin_d_reg;
  logic [3:0]             pre_cnt_reg;
  logic [1:0]             cpi_cnt_reg;

  wire icc_pkg::icc_mode_t mode;
  wire icc_pkg::icc_tsel_t tsel;
  wire [1:0]              cpi;
  wire                    idle_stop;

  assign mode      = icc_pkg::icc_mode_t'(ctrl_reg[`ICC_MODE_HI:`ICC_MODE_LO]);
  assign tsel      = icc_pkg::icc_tsel_t'(ctrl_reg[`ICC_TSEL_HI:`ICC_TSEL_LO]);
  assign cpi       = ctrl_reg[`ICC_CPI_HI:`ICC_CPI_LO];
  assign idle_stop = ctrl_reg[`ICC_BIT_IDLE_STOP];

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wr_ctrl = REG_WR_I & (REG_ADDR_I == `ICC_OFF_CTRL);
  wire wr_stat = REG_WR_I & (REG_ADDR_I == `ICC_OFF_IRQ_STAT);
  wire wr_mask = REG_WR_I & (REG_ADDR_I == `ICC_OFF_IRQ_MASK);
  wire rd_buf  = REG_RD_I & (REG_ADDR_I == `ICC_OFF_BUF);

  // ----------------------------------------------------------------
  // Time-base selection
  // ----------------------------------------------------------------
  logic [TB_W-1:0] tb_value;
  logic            tb_valid;

  // Reserved codes give no source, so captures are suppressed
  always_comb begin
    tb_value = '0;
    tb_valid = 1'b1;
    unique case (tsel)
      icc_pkg::ICC_TB_PCLK: tb_value = PCLK_VAL_I;
      icc_pkg::ICC_TB_RES5,
      icc_pkg::ICC_TB_RES6: tb_valid = 1'b0;
      icc_pkg::ICC_TB_TMR3: tb_value = TMR3_VAL_I;
      icc_pkg::ICC_TB_TMR2: tb_value = TMR2_VAL_I;
      icc_pkg::ICC_TB_TMR4: tb_value = TMR4_VAL_I;
      icc_pkg::ICC_TB_TMR5: tb_value = TMR5_VAL_I;
      // Timer one value is taken synchronous to the core clock only
      icc_pkg::ICC_TB_TMR1: tb_value = TMR1_VAL_I;
    endcase
  end

  // ----------------------------------------------------------------
  // Edge detection and prescaler
  // ----------------------------------------------------------------
  wire rise = CAPT_PIN_I & ~pin_d_reg;
  wire fall = ~CAPT_PIN_I & pin_d_reg;

  wire halted  = idle_stop & CPU_IDLE_I;
  wire cap_on  = (mode != icc_pkg::ICC_MODE_OFF) &&
                 (mode != icc_pkg::ICC_MODE_UNUSED) &&
                 (mode != icc_pkg::ICC_MODE_WAKE);
  wire run     = cap_on & ~halted & tb_valid;

  wire pre4_hit  = rise & (pre_cnt_reg[1:0] == 2'(`ICC_PRE4_LAST));
  wire pre16_hit = rise & (pre_cnt_reg == `ICC_PRE16_LAST);

  logic edge_hit;
  always_comb begin
    edge_hit = 1'b0;
    unique case (mode)
      icc_pkg::ICC_MODE_BOTH:  edge_hit = rise | fall;
      icc_pkg::ICC_MODE_FALL:  edge_hit = fall;
      icc_pkg::ICC_MODE_RISE:  edge_hit = rise;
      icc_pkg::ICC_MODE_PRE4:  edge_hit = pre4_hit;
      icc_pkg::ICC_MODE_PRE16: edge_hit = pre16_hit;
      icc_pkg::ICC_MODE_OFF,
      icc_pkg::ICC_MODE_UNUSED,
      icc_pkg::ICC_MODE_WAKE:  edge_hit = 1'b0;
    endcase
  end

  wire capture = run & edge_hit;
  // Wake pin works only in sleep or idle, ignoring other settings
  wire wake_ev = (mode == icc_pkg::ICC_MODE_WAKE) & rise &
                 (CPU_SLEEP_I | CPU_IDLE_I);

  wire pre_mode = (mode == icc_pkg::ICC_MODE_PRE4) ||
                  (mode == icc_pkg::ICC_MODE_PRE16);
  logic [3:0] pre_cnt_next;
  assign pre_cnt_next = !pre_mode ? 4'h0 :
                        (run & rise) ? pre_cnt_reg + 4'h1 : pre_cnt_reg;

  // ----------------------------------------------------------------
  // Capture buffer
  // ----------------------------------------------------------------
  wire             fifo_ready;
  wire             fifo_valid;
  wire [TB_W-1:0]  fifo_data;
  // Buffer is flushed when the channel is turned off
  wire             flush = ~cap_on;

  icc_fifo #(
    .WIDTH (TB_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i        (CORE_CLK_I),
    .rst_b_i      (RST_B_I),
    .push_valid_i (capture),
    .push_ready_o (fifo_ready),
    .push_data_i  (tb_value),
    .pop_valid_o  (fifo_valid),
    .pop_ready_i  (rd_buf),
    .pop_data_o   (fifo_data),
    .flush_i      (flush)
  );

  wire ovf_set   = capture & ~fifo_ready;
  wire ovf_next  = ovf_set ? 1'b1 :
                   (~fifo_valid | flush) ? 1'b0 : ovf_reg;

  // ----------------------------------------------------------------
  // Captures per interrupt
  // ----------------------------------------------------------------
  wire        cpi_used = (mode != icc_pkg::ICC_MODE_BOTH);
  wire        cpi_done = ~cpi_used | (cpi_cnt_reg == cpi);
  wire        capt_irq = capture & cpi_done;
  logic [1:0] cpi_cnt_next;
  assign cpi_cnt_next = !cap_on ? 2'h0 :
                        !capture ? cpi_cnt_reg :
                        cpi_done ? 2'h0 : cpi_cnt_reg + 2'h1;

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  wire [`ICC_IRQ_W-1:0] irq_ev = {wake_ev, ovf_set, capt_irq};
  wire [`ICC_IRQ_W-1:0] irq_clr = wr_stat ? REG_WDATA_I[`ICC_IRQ_W-1:0]
                                          : '0;
  // Set wins over a simultaneous write-one clear
  wire [`ICC_IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;
  wire                  irq_next = |(irq_stat_next & irq_mask_reg);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [15:0] ctrl_view = (ctrl_reg & `ICC_CTRL_WMASK) |
                          (16'(ovf_reg)    << `ICC_BIT_OVF) |
                          (16'(fifo_valid) << `ICC_BIT_BNE);
  logic [15:0] rdata_next;
  always_comb begin
    rdata_next = 16'h0000;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        `ICC_OFF_CTRL:     rdata_next = ctrl_view;
        `ICC_OFF_BUF:      rdata_next = fifo_valid ? 16'(fifo_data) : 16'h0;
        `ICC_OFF_IRQ_STAT: rdata_next = 16'(irq_stat_reg);
        `ICC_OFF_IRQ_MASK: rdata_next = 16'(irq_mask_reg);
        `ICC_OFF_TIMEBASE: rdata_next = 16'(tb_value);
        default:           rdata_next = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl_reg     <= `ICC_CTRL_RESET;
      irq_mask_reg <= '0;
      irq_stat_reg <= '0;
    end else begin
      // Status bits are never stored from a write
      if (wr_ctrl) begin
        ctrl_reg <= REG_WDATA_I & `ICC_CTRL_WMASK;
      end
      if (wr_mask) begin
        irq_mask_reg <= REG_WDATA_I[`ICC_IRQ_W-1:0];
      end
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pin_d_reg   <= 1'b0;
      pre_cnt_reg <= 4'h0;
      cpi_cnt_reg <= 2'h0;
      ovf_reg     <= 1'b0;
      rdata_reg   <= 16'h0000;
      irq_reg     <= 1'b0;
    end else begin
      pin_d_reg   <= CAPT_PIN_I;
      pre_cnt_reg <= pre_cnt_next;
      cpi_cnt_reg <= cpi_cnt_next;
      ovf_reg     <= ovf_next;
      rdata_reg   <= rdata_next;
      irq_reg     <= irq_next;
    end
  end

  assign REG_RDATA_O = rdata_reg;
  assign IRQ_O       = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_idle_halt_push: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) halted |-> !capture)
    else $error("capture while halted in idle");

  chk_tsel_pclk: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) (tsel == icc_pkg::ICC_TB_PCLK)
      |-> tb_value == PCLK_VAL_I)
    else $error("peripheral clock not selected");

  chk_tsel_reserved: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) (tsel == icc_pkg::ICC_TB_RES5 ||
      tsel == icc_pkg::ICC_TB_RES6) |-> !capture)
    else $error("capture from a reserved time base");

  chk_tsel_timer3: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) (tsel == icc_pkg::ICC_TB_TMR3)
      |-> tb_value == TMR3_VAL_I)
    else $error("timer three not selected");

  chk_tsel_timer1: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) (tsel == icc_pkg::ICC_TB_TMR1)
      |-> tb_value == TMR1_VAL_I)
    else $error("timer one not selected");

  chk_cpi_irq_count: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) capt_irq && cpi_used
      |-> cpi_cnt_reg == cpi)
    else $error("interrupt at wrong capture count");

  chk_edge_mode_irq: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) capture && !cpi_used |-> capt_irq)
    else $error("edge mode capture without interrupt");

  chk_ovf_set_hold: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) ovf_set |=> ovf_reg)
    else $error("overflow flag not set");

  chk_ovf_hw_clear: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) !fifo_valid && !ovf_set |=> !ovf_reg)
    else $error("overflow flag kept with empty buffer");

  chk_bne_follows: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) REG_RD_I && REG_ADDR_I == `ICC_OFF_CTRL
      |=> REG_RDATA_O[`ICC_BIT_BNE] == $past(fifo_valid))
    else $error("not-empty flag wrong");

  // Flush lands one edge after the channel goes off
  chk_off_no_capture: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) !cap_on |-> !capture ##1 !fifo_valid)
    else $error("capture while disabled");

  chk_both_edges: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) mode == icc_pkg::ICC_MODE_BOTH && run &&
      $changed(CAPT_PIN_I) |-> capture)
    else $error("edge mode missed a pin change");

  chk_fall_only: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) mode == icc_pkg::ICC_MODE_FALL && capture
      |-> $fell(CAPT_PIN_I))
    else $error("falling mode took non-falling edge");

  chk_rise_only: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) mode == icc_pkg::ICC_MODE_RISE && capture
      |-> $rose(CAPT_PIN_I))
    else $error("rising mode took non-rising edge");

  chk_pre4_spacing: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) capture && mode == icc_pkg::ICC_MODE_PRE4
      |=> pre_cnt_reg[1:0] == 2'h0)
    else $error("fourth-edge prescaler misaligned");

  chk_pre16_spacing: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) capture && mode == icc_pkg::ICC_MODE_PRE16
      |=> pre_cnt_reg == 4'h0)
    else $error("sixteenth-edge prescaler misaligned");

  chk_wake_no_push: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) mode == icc_pkg::ICC_MODE_WAKE
      |-> !capture)
    else $error("wake mode stored a capture");

  chk_wake_status: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) mode == icc_pkg::ICC_MODE_WAKE &&
      $rose(CAPT_PIN_I) && (CPU_SLEEP_I || CPU_IDLE_I)
      |=> irq_stat_reg[`ICC_IRQ_WAKE])
    else $error("wake edge did not set status");

  chk_capture_push: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) capture && fifo_ready |=> fifo_valid)
    else $error("accepted capture not buffered");

  chk_drop_on_full: assert property (@(posedge CORE_CLK_I)
    disable iff (!RST_B_I) ovf_set |-> !fifo_ready)
    else $error("overflow without full buffer");

endmodule

// ---- pkg/icc_params.svh ----
// Register offsets, field positions, reset values and codes of the capture channel
`ifndef ICC_PARAMS_SVH
`define ICC_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (word offsets on the plain port)
// ----------------------------------------------------------------
`define ICC_ADDR_W        4
`define ICC_OFF_CTRL      4'h0
`define ICC_OFF_BUF       4'h1
`define ICC_OFF_IRQ_STAT  4'h2
`define ICC_OFF_IRQ_MASK  4'h3
`define ICC_OFF_TIMEBASE  4'h4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ICC_BIT_IDLE_STOP 13
`define ICC_TSEL_HI       12
`define ICC_TSEL_LO       10
`define ICC_CPI_HI        6
`define ICC_CPI_LO        5
`define ICC_BIT_OVF       4
`define ICC_BIT_BNE       3
`define ICC_MODE_HI       2
`define ICC_MODE_LO       0
`define ICC_CTRL_WMASK    16'h3C67
`define ICC_CTRL_RESET    16'h0000

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define ICC_IRQ_CAPT      0
`define ICC_IRQ_OVF       1
`define ICC_IRQ_WAKE      2
`define ICC_IRQ_W         3

// ----------------------------------------------------------------
// Prescaler counts
// ----------------------------------------------------------------
`define ICC_PRE4_LAST     4'h3
`define ICC_PRE16_LAST    4'hF

`endif

// ---- pkg/icc_pkg.sv ----
// Types of the capture channel
package icc_pkg;

  typedef enum logic [2:0] {
    ICC_MODE_OFF   = 3'b000,
    ICC_MODE_BOTH  = 3'b001,
    ICC_MODE_FALL  = 3'b010,
    ICC_MODE_RISE  = 3'b011,
    ICC_MODE_PRE4  = 3'b100,
    ICC_MODE_PRE16 = 3'b101,
    ICC_MODE_UNUSED = 3'b110,
    ICC_MODE_WAKE  = 3'b111
  } icc_mode_t;

  typedef enum logic [2:0] {
    ICC_TB_TMR3  = 3'b000,
    ICC_TB_TMR2  = 3'b001,
    ICC_TB_TMR4  = 3'b010,
    ICC_TB_TMR5  = 3'b011,
    ICC_TB_TMR1  = 3'b100,
    ICC_TB_RES5  = 3'b101,
    ICC_TB_RES6  = 3'b110,
    ICC_TB_PCLK  = 3'b111
  } icc_tsel_t;

endpackage

// ---- core/icc_fifo.sv ----
// Small capture buffer held in flip-flops
`timescale 1ns/1ps
`include "icc_params.svh"

module icc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // Filling side
  input  wire logic             push_valid_i,
  output logic                  push_ready_o,
  input  wire logic [WIDTH-1:0] push_data_i,
  // Draining side
  output logic                  pop_valid_o,
  input  wire logic             pop_ready_i,
  output logic [WIDTH-1:0]      pop_data_o,
  // Flush
  input  wire logic             flush_i
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  wire              do_push;
  wire              do_pop;

  assign push_ready_o = (count_reg != (PW+1)'(DEPTH));
  assign pop_valid_o  = (count_reg != '0);
  assign pop_data_o   = mem_reg[rd_ptr_reg];
  assign do_push      = push_valid_i & push_ready_o & ~flush_i;
  assign do_pop       = pop_valid_o & pop_ready_i & ~flush_i;

  // Storage carries no reset; only the pointers and the count need a defined value
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{PW{1'b0}}, do_push} - {{PW{1'b0}}, do_pop};
    end
  end

endmodule

// ---- test/icc_pin_model.sv ----
// Capture pin source standing in for the external signal
`timescale 1ns/1ps

module icc_pin_model (
  // Clock
  input  wire logic clk_i,
  // Capture pin
  output logic      pin_o
);
  initial pin_o = 1'b0;

  // Level change lands just after a rising edge, then holds
  task automatic set_level(input logic lvl, input int hold);
    @(posedge clk_i);
    pin_o <= lvl;
    repeat (hold) @(posedge clk_i);
  endtask

  // Full pulses; a larger hold gives a slow source
  task automatic pulse(input int n, input int hold);
    repeat (n) begin
      set_level(1'b1, hold);
      set_level(1'b0, hold);
    end
  endtask
endmodule

// ---- test/input_capture_control_test.sv ----
// Self-checking bench for the input capture channel
`timescale 1ns/1ps
`include "icc_params.svh"

module input_capture_control_test;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk;
  logic        rst_b;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [15:0] rdata;
  logic        pin_lvl;
  logic        idle;
  logic        sleep;
  logic [15:0] t1, t2, t3, t4, t5, pc;
  logic        irq;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [15:0] tbv [8];
  int          mexp [8] = '{0, 4, 2, 2, 0, 0, 0, 0};

  icc_pin_model pin (
    .clk_i (clk),
    .pin_o (pin_lvl)
  );

  icc_top #(.TB_W(16), .DEPTH(4)) dut (
    .CORE_CLK_I  (clk),
    .RST_B_I     (rst_b),
    .REG_ADDR_I  (addr),
    .REG_WDATA_I (wdata),
    .REG_WR_I    (wr_s),
    .REG_RD_I    (rd_s),
    .REG_RDATA_O (rdata),
    .CAPT_PIN_I  (pin_lvl),
    .CPU_IDLE_I  (idle),
    .CPU_SLEEP_I (sleep),
    .TMR1_VAL_I  (t1),
    .TMR2_VAL_I  (t2),
    .TMR3_VAL_I  (t3),
    .TMR4_VAL_I  (t4),
    .TMR5_VAL_I  (t5),
    .PCLK_VAL_I  (pc),
    .IRQ_O       (irq)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard, well above the roughly one thousand cycles of the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Interrupt level taken mid-cycle, away from the edge that moves it
  task automatic ci(input logic e);
    @(negedge clk);
    check({15'h0000, irq}, {15'h0000, e});
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    check(d, e);
  endtask

  // Off first: flushes the buffer and clears the counters
  task automatic ctl(input logic [15:0] v);
    wr(`ICC_OFF_CTRL, 16'h0000);
    wr(`ICC_OFF_IRQ_STAT, 16'h0007);
    wr(`ICC_OFF_CTRL, v);
  endtask

  task automatic drain(input int e);
    logic [15:0] d;
    int          n;
    n = 0;
    repeat (6) begin
      rd(`ICC_OFF_CTRL, d);
      if (d[`ICC_BIT_BNE] === 1'b1) begin
        rd(`ICC_OFF_BUF, d);
        n++;
      end
    end
    check(16'(n), 16'(e));
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    idle = 1'b0;
    sleep = 1'b0;
    t1 = 16'h1111;
    t2 = 16'h2222;
    t3 = 16'h3333;
    t4 = 16'h4444;
    t5 = 16'h5555;
    pc = 16'h7777;
    tbv = '{16'h3333, 16'h2222, 16'h4444, 16'h5555,
            16'h1111, 16'h0000, 16'h0000, 16'h7777};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rc(`ICC_OFF_CTRL, 16'h0000);
    rc(`ICC_OFF_IRQ_STAT, 16'h0000);
    rc(`ICC_OFF_IRQ_MASK, 16'h0000);
    rc(`ICC_OFF_BUF, 16'h0000);
    wr(4'hA, 16'hFFFF);
    rc(4'hA, 16'h0000);
    wr(`ICC_OFF_CTRL, 16'hFFFF);
    rc(`ICC_OFF_CTRL, `ICC_CTRL_WMASK);
    for (int i = 0; i < 8; i++) begin
      ctl({3'h0, i[2:0], 10'h003});
      pin.pulse(1, 3);
      rc(`ICC_OFF_BUF, tbv[i]);
      rc(`ICC_OFF_TIMEBASE, tbv[i]);
    end
    for (int i = 0; i < 8; i++) begin
      ctl({13'h0000, i[2:0]});
      pin.pulse(2, 3);
      drain(mexp[i]);
    end
    ctl(16'h0004);
    pin.pulse(7, 1);
    drain(1);
    pin.pulse(1, 1);
    drain(1);
    ctl(16'h0005);
    pin.pulse(15, 1);
    drain(0);
    pin.pulse(1, 1);
    drain(1);
    wr(`ICC_OFF_IRQ_MASK, 16'h0001);
    for (int c = 0; c < 4; c++) begin
      ctl({9'h000, c[1:0], 5'h03});
      pin.pulse(c, 3);
      ci(1'b0);
      pin.pulse(1, 3);
      ci(1'b1);
    end
    ctl(16'h0061);
    pin.set_level(1'b1, 3);
    ci(1'b1);
    pin.set_level(1'b0, 3);
    wr(`ICC_OFF_IRQ_MASK, 16'h0004);
    ctl(16'h0007);
    @(posedge clk) sleep <= 1'b1;
    pin.set_level(1'b1, 3);
    rc(`ICC_OFF_IRQ_STAT, 16'h0004);
    ci(1'b1);
    wr(`ICC_OFF_IRQ_STAT, 16'h0004);
    pin.set_level(1'b0, 3);
    rc(`ICC_OFF_IRQ_STAT, 16'h0000);
    @(posedge clk) sleep <= 1'b0;
    pin.pulse(1, 3);
    rc(`ICC_OFF_IRQ_STAT, 16'h0000);
    rc(`ICC_OFF_CTRL, 16'h0007);
    ctl(16'h2003);
    @(posedge clk) idle <= 1'b1;
    pin.pulse(1, 3);
    rc(`ICC_OFF_CTRL, 16'h2003);
    wr(`ICC_OFF_CTRL, 16'h0003);
    pin.pulse(1, 3);
    rc(`ICC_OFF_CTRL, 16'h000B);
    ci(1'b0);
    @(posedge clk) idle <= 1'b0;
    // Five captures into a four-deep buffer
    ctl(16'h0003);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) t3 <= 16'hA000 + 16'(i);
      pin.pulse(1, 3);
    end
    wr(`ICC_OFF_CTRL, 16'h0003);
    rc(`ICC_OFF_CTRL, 16'h001B);
    rc(`ICC_OFF_IRQ_STAT, 16'h0003);
    for (int i = 0; i < 4; i++)
      rc(`ICC_OFF_BUF, 16'hA000 + 16'(i));
    rc(`ICC_OFF_CTRL, 16'h0003);
    stop_test();
  end
endmodule
